// ---- hw/tone_decode.sv ----
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`include "tone_decode_regs.svh"
module tone_decode import tone_decode_pkg::*; #(
  parameter int DETECT_CYCLES = `PRESENCE_DETECT_US * `CLK_MHZ,
  parameter int TICK_CYCLES   = `GUARD_TICK_US * `CLK_MHZ,
  // multiplies every tone rate; 1 for real tones, larger only to shorten runs
  // limitation: a large scale coarsens the period windows of the meters
  parameter int TONE_SCALE    = 1
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // limited tones from the filter comparators
  input  wire logic        LOW_TONE,
  input  wire logic        HIGH_TONE,
  // steering pin: comparator level in, guard drive out
  input  wire logic        STEER_IN,
  output logic             GUARD_DRIVE_OUT,
  output logic             GUARD_DRIVE_OE,
  // code bus
  input  wire logic        CODE_OUTPUT_ENABLE,
  output logic [3:0]       CODE_OUT,
  output logic             CODE_OE,
  // flags
  output logic             EARLY_DETECT_FLAG,
  output logic             DELAYED_STEER_FLAG,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // interrupt
  output logic             IRQ
);
  localparam int SETTLE_CYCLES =
    (`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  logic         low_s, high_s, steer_s, toe_s;
  logic         low_ok, high_ok;
  tone_idx_t    low_idx, high_idx;
  logic         pair_ok;
  logic [3:0]   pair_key;
  logic [3:0]   det_key_q;
  logic [16:0]  det_cnt_q;
  logic         early_q;
  logic [14:0]  tick_cnt_q;
  logic         tick;
  logic [15:0]  guard_cnt_q;
  logic         steer_int_q;
  logic         steer;
  logic         steer_prev_q;
  logic         steer_rise, steer_fall;
  key_code_t    code_q;
  steer_state_t st_q;
  logic [6:0]   settle_q;
  logic         stdf_q;
  logic         ext_steer_q;
  logic [15:0]  gtp_q, gta_q;
  logic [2:0]   irq_stat_q, irq_en_q, ev;
  logic         early_prev_q, reg_seen_q;
  logic         ack_q;
  logic         req;

  sync2 u_sync_low   (.clk(CLK), .rst(RST), .d(LOW_TONE),           .q(low_s));
  sync2 u_sync_high  (.clk(CLK), .rst(RST), .d(HIGH_TONE),          .q(high_s));
  sync2 u_sync_steer (.clk(CLK), .rst(RST), .d(STEER_IN),           .q(steer_s));
  sync2 u_sync_toe   (.clk(CLK), .rst(RST), .d(CODE_OUTPUT_ENABLE), .q(toe_s));

  tone_meter #(
    .F0(`ROW0_HZ * TONE_SCALE), .F1(`ROW1_HZ * TONE_SCALE),
    .F2(`ROW2_HZ * TONE_SCALE), .F3(`ROW3_HZ * TONE_SCALE)
  ) u_low (
    .clk(CLK), .rst(RST), .tone(low_s), .valid(low_ok), .idx(low_idx));
  tone_meter #(
    .F0(`COL0_HZ * TONE_SCALE), .F1(`COL1_HZ * TONE_SCALE),
    .F2(`COL2_HZ * TONE_SCALE), .F3(`COL3_HZ * TONE_SCALE)
  ) u_high (
    .clk(CLK), .rst(RST), .tone(high_s), .valid(high_ok), .idx(high_idx));

  // key map
  always_comb begin
    if (high_idx == 2'd3) begin
      pair_key = (low_idx == 2'd3) ? 4'h0 : {2'b11, low_idx} + 4'h1;
    end else if (low_idx == 2'd3) begin
      case (high_idx)
        2'd0:    pair_key = 4'hb;
        2'd1:    pair_key = 4'ha;
        default: pair_key = 4'hc;
      endcase
    end else begin
      pair_key = 4'((low_idx * 3) + high_idx + 1);
    end
  end
  assign pair_ok = low_ok && high_ok;

  // presence detection; loss drops the flag at once
  always_ff @(posedge CLK) begin
    if (RST) begin
      det_cnt_q <= 17'h00000;
      det_key_q <= 4'h0;
      early_q   <= 1'b0;
    end else if (!pair_ok || pair_key != det_key_q) begin
      det_cnt_q <= 17'h00000;
      det_key_q <= pair_key;
      early_q   <= 1'b0;
    end else if (int'(det_cnt_q) >= DETECT_CYCLES - 1) begin
      early_q <= 1'b1;
    end else begin
      det_cnt_q <= det_cnt_q + 17'h00001;
    end
  end
  assign EARLY_DETECT_FLAG = early_q;

  // guard prescaler, one tick per guard unit
  assign tick = (int'(tick_cnt_q) == TICK_CYCLES - 1);
  always_ff @(posedge CLK) begin
    if (RST || tick) begin
      tick_cnt_q <= 15'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 15'h0001;
    end
  end

  // internal steering: early flag must differ for a whole guard time
  always_ff @(posedge CLK) begin
    if (RST) begin
      guard_cnt_q <= 16'h0000;
      steer_int_q <= 1'b0;
    end else if (early_q == steer_int_q) begin
      guard_cnt_q <= 16'h0000;
    end else if (guard_cnt_q >= (steer_int_q ? gta_q : gtp_q)) begin
      guard_cnt_q <= 16'h0000;
      steer_int_q <= early_q;
    end else if (tick) begin
      guard_cnt_q <= guard_cnt_q + 16'h0001;
    end
  end

  assign steer = ext_steer_q ? steer_s : steer_int_q;
  assign steer_rise = steer && !steer_prev_q;
  assign steer_fall = !steer && steer_prev_q;

  // registration and delayed flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      steer_prev_q <= 1'b0;
      st_q         <= ST_IDLE;
      settle_q     <= 7'h00;
      stdf_q       <= 1'b0;
      code_q       <= `CODE_RST;
    end else begin
      steer_prev_q <= steer;
      case (st_q)
        ST_IDLE: begin
          if (steer_rise) begin
            code_q   <= det_key_q;
            settle_q <= 7'h00;
            st_q     <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!steer) begin
            st_q <= ST_IDLE;
          end else if (int'(settle_q) >= SETTLE_CYCLES - 1) begin
            stdf_q <= 1'b1;
            st_q   <= ST_HELD;
          end else begin
            settle_q <= settle_q + 7'h01;
          end
        end
        ST_HELD: begin
          if (!steer) begin
            stdf_q <= 1'b0;
            st_q   <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign DELAYED_STEER_FLAG = stdf_q;

  // guard drive resets the external time constant while tone persists and the state is not ST_IDLE
  assign GUARD_DRIVE_OUT = (st_q != ST_IDLE) && early_q;
  assign GUARD_DRIVE_OE  = GUARD_DRIVE_OUT;

  // latched code goes out under the synced enable
  assign CODE_OUT = code_q;
  assign CODE_OE  = toe_s;

  // events
  always_ff @(posedge CLK) begin
    if (RST) begin
      early_prev_q <= 1'b0;
      reg_seen_q   <= 1'b0;
    end else begin
      early_prev_q <= early_q;
      if (early_q && !early_prev_q) begin
        reg_seen_q <= 1'b0;
      end else if (steer_rise) begin
        reg_seen_q <= 1'b1;
      end
    end
  end
  always_comb begin
    ev = 3'h0;
    ev[`EV_REGISTERED_BIT] = (st_q == ST_SETTLE) && (int'(settle_q) >= SETTLE_CYCLES - 1)
                             && steer;
    ev[`EV_PAUSE_BIT]      = (st_q == ST_HELD) && !steer;
    // burst ended with no registration since it began
    ev[`EV_REJECT_BIT]     = !early_q && early_prev_q && !reg_seen_q && !steer;
  end

  // bus: one wait cycle, request taken when waitrequest is low
  assign req             = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !ack_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_q        <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end else begin
      ack_q <= req && !ack_q;
      if (AVS_READ && !ack_q) begin
        case (AVS_ADDRESS)
          `REG_CTRL_OFS:     AVS_READDATA <= {31'h0, ext_steer_q};
          `REG_STATUS_OFS:   AVS_READDATA <= {26'h0, st_q, toe_s, steer, stdf_q, early_q};
          `REG_CODE_OFS:     AVS_READDATA <= {28'h0, code_q};
          `REG_GTP_OFS:      AVS_READDATA <= {16'h0, gtp_q};
          `REG_GTA_OFS:      AVS_READDATA <= {16'h0, gta_q};
          `REG_IRQ_STAT_OFS: AVS_READDATA <= {29'h0, irq_stat_q};
          `REG_IRQ_EN_OFS:   AVS_READDATA <= {29'h0, irq_en_q};
          default:           AVS_READDATA <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ext_steer_q <= `CTRL_RST;
      gtp_q       <= `GTP_RST;
      gta_q       <= `GTA_RST;
      irq_en_q    <= `IRQ_EN_RST;
    end else if (AVS_WRITE && ack_q) begin
      case (AVS_ADDRESS)
        `REG_CTRL_OFS:   ext_steer_q <= AVS_WRITEDATA[`CTRL_EXT_STEER_BIT];
        `REG_GTP_OFS:    gtp_q       <= AVS_WRITEDATA[15:0];
        `REG_GTA_OFS:    gta_q       <= AVS_WRITEDATA[15:0];
        `REG_IRQ_EN_OFS: irq_en_q    <= AVS_WRITEDATA[2:0];
        default: ;
      endcase
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat_q <= 3'h0;
    end else if (AVS_WRITE && ack_q && AVS_ADDRESS == `REG_IRQ_CLR_OFS) begin
      irq_stat_q <= (irq_stat_q & ~AVS_WRITEDATA[2:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end
  assign IRQ = |(irq_stat_q & irq_en_q);

  // checks
  sequence s_settled;
    (st_q == ST_SETTLE) [*8];
  endsequence

  a_early_loss_drop: assert property (@(posedge CLK) disable iff (RST)
    !pair_ok |=> !early_q)
    else $error("early flag held after pair loss");
  a_latch_on_rise: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_IDLE && steer_rise) |=> (code_q == $past(det_key_q)))
    else $error("code not latched on steering rise");
  a_guard_drive_hold: assert property (@(posedge CLK) disable iff (RST)
    stdf_q && early_q |-> GUARD_DRIVE_OUT)
    else $error("guard drive low while tone held");
  a_stdf_setup_time: assert property (@(posedge CLK) disable iff (RST)
    $rose(stdf_q) |-> $stable(code_q) && ($past(st_q) == ST_SETTLE) &&
      (int'(settle_q) == SETTLE_CYCLES - 1))
    else $error("delayed flag rose without settling");
  a_stdf_after_settle: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_SETTLE && steer && int'(settle_q) >= SETTLE_CYCLES - 1) |=> stdf_q)
    else $error("delayed flag late after latch");
  a_stdf_fall_steer: assert property (@(posedge CLK) disable iff (RST)
    stdf_q && !steer |=> !stdf_q)
    else $error("delayed flag held after steering drop");
  a_no_reg_held: assert property (@(posedge CLK) disable iff (RST)
    steer && steer_prev_q |=> $stable(code_q))
    else $error("code changed while steering held");
  a_code_oe_follow: assert property (@(posedge CLK) disable iff (RST)
    CODE_OE == toe_s && CODE_OUT == code_q)
    else $error("code bus not following latch and enable");
  a_short_burst: assert property (@(posedge CLK) disable iff (RST)
    (!ext_steer_q && !steer_int_q && !early_q) |=> !$rose(steer_int_q))
    else $error("steering rose without tone");
  a_settle_steps: assert property (@(posedge CLK) disable iff (RST)
    s_settled |-> !stdf_q)
    else $error("delayed flag high during settle");
  a_reset_state: assert property (@(posedge CLK)
    RST |=> !early_q && !stdf_q && code_q == `CODE_RST)
    else $error("reset left flags set");
endmodule // tone_decode

// ---- hw/tone_decode_regs.svh ----
`ifndef TONE_DECODE_REGS_SVH
`define TONE_DECODE_REGS_SVH

// register byte offsets
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_CODE_OFS      8'h08
`define REG_GTP_OFS       8'h0c
`define REG_GTA_OFS       8'h10
`define REG_IRQ_STAT_OFS  8'h14
`define REG_IRQ_EN_OFS    8'h18
`define REG_IRQ_CLR_OFS   8'h1c

// field positions
`define CTRL_EXT_STEER_BIT 0
`define EV_REGISTERED_BIT  0
`define EV_PAUSE_BIT       1
`define EV_REJECT_BIT      2

// reset values
`define CTRL_RST       1'b0
`define GTP_RST        16'h001e
`define GTA_RST        16'h001e
`define CODE_RST       4'h0
`define IRQ_EN_RST     3'h0

// timing
`define CLK_HZ              20000000
`define CLK_MHZ             20
`define PRESENCE_DETECT_US  5000
`define GUARD_TICK_US       1000
`define SETTLE_NS           4000
`define CLK_PERIOD_NS       50
`define TOL_PER_MILLE       25

// tone frequencies in Hz
`define ROW0_HZ 697
`define ROW1_HZ 770
`define ROW2_HZ 852
`define ROW3_HZ 941
`define COL0_HZ 1209
`define COL1_HZ 1336
`define COL2_HZ 1477
`define COL3_HZ 1633

`endif

// ---- hw/tone_decode_pkg.sv ----
package tone_decode_pkg;
  typedef logic [1:0] tone_idx_t;
  typedef logic [3:0] key_code_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_HELD   = 2'b10
  } steer_state_t;
endpackage

// ---- hw/sync2.sv ----
module sync2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sync2

// ---- hw/tone_meter.sv ----
`include "tone_decode_regs.svh"
module tone_meter import tone_decode_pkg::*; #(
  parameter int F0 = `ROW0_HZ,
  parameter int F1 = `ROW1_HZ,
  parameter int F2 = `ROW2_HZ,
  parameter int F3 = `ROW3_HZ
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tone,
  output logic      valid,
  output tone_idx_t idx
);
  localparam int FREQ[4] = '{F0, F1, F2, F3};
  logic [15:0] cnt_q;
  logic        tone_q;
  logic        prev_ok_q;
  tone_idx_t   prev_idx_q;
  logic        hit;
  tone_idx_t   hit_idx;

  // period window per tone, tolerance between accept and reject limits
  always_comb begin
    hit     = 1'b0;
    hit_idx = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (int'(cnt_q) >= (`CLK_HZ / FREQ[i]) * 1000 / (1000 + `TOL_PER_MILLE) &&
          int'(cnt_q) <= (`CLK_HZ / FREQ[i]) * 1000 / (1000 - `TOL_PER_MILLE)) begin
        hit     = 1'b1;
        hit_idx = tone_idx_t'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q      <= 16'h0000;
      tone_q     <= 1'b0;
      prev_ok_q  <= 1'b0;
      prev_idx_q <= 2'd0;
      valid      <= 1'b0;
      idx        <= 2'd0;
    end else begin
      tone_q <= tone;
      if (tone && !tone_q) begin
        cnt_q      <= 16'h0001;
        prev_ok_q  <= hit;
        prev_idx_q <= hit_idx;
        // two matching periods in a row guard against voice talk-off
        valid      <= hit && prev_ok_q && (hit_idx == prev_idx_q);
        idx        <= hit_idx;
      end else if (int'(cnt_q) > (`CLK_HZ / F0) * 1000 / (1000 - `TOL_PER_MILLE)) begin
        valid     <= 1'b0;
        prev_ok_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // tone_meter

// ---- sim/code_reader.sv ----
module code_reader (
  // clock
  input  wire logic       clk,
  // code bus from the receiver
  input  wire logic       code_oe,
  input  wire logic [3:0] code_out,
  // enable back to the receiver
  output logic            code_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] last_q = 4'h0;
  logic [3:0] bus_q;
  // no pull on the code lines: a released bus must not look like a held copy
  always @(posedge clk) begin
    if (code_oe === 1'b1) last_q <= code_out;
  end
  assign bus_q = (code_oe === 1'b1) ? code_out : ~last_q;
  initial code_enable = 1'b0;
  task automatic read_code(output logic [3:0] v);
    int n;
    n = 0;
    @(posedge clk);
    code_enable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (code_oe !== 1'b1 && n < 20);
    v = (n < 20) ? bus_q : 4'hx;
    code_enable <= 1'b0;
  endtask
endmodule // code_reader

// ---- sim/test_dual_tone_decode_steering.sv ----
`include "tone_decode_regs.svh"
module test_dual_tone_decode_steering import tone_decode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK = 1'b0, RST = 1'b1, LOW_TONE = 1'b0, HIGH_TONE = 1'b0;
  logic        STEER_IN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
  logic        CODE_OUTPUT_ENABLE, GUARD_DRIVE_OUT, GUARD_DRIVE_OE, CODE_OE;
  logic        EARLY_DETECT_FLAG, DELAYED_STEER_FLAG, AVS_WAITREQUEST, IRQ;
  logic [3:0]  CODE_OUT, code_prev, rd4;
  logic        tone_on = 1'b0, ds_prev;
  int          error_cnt = 0, checked = 0, cyc = 0, chg_t = 0;
  int          lo_half = 1, hi_half = 1, lo_cnt = 0, hi_cnt = 0;
  // low tone, high tone, expected code
  localparam int key_rows [16][3] = '{
    '{697, 1209, 1}, '{697, 1336, 2}, '{697, 1477, 3}, '{770, 1209, 4},
    '{770, 1336, 5}, '{770, 1477, 6}, '{852, 1209, 7}, '{852, 1336, 8},
    '{852, 1477, 9}, '{941, 1336, 10}, '{941, 1209, 11}, '{941, 1477, 12},
    '{697, 1633, 13}, '{770, 1633, 14}, '{852, 1633, 15}, '{941, 1633, 0}};

  // guard counts shortened and tone rates scaled up so the whole run stays short
  localparam int SCALE = 64;
  tone_decode #(.DETECT_CYCLES(200), .TICK_CYCLES(50), .TONE_SCALE(SCALE)) dut (
    .CLK, .RST, .LOW_TONE, .HIGH_TONE, .STEER_IN, .GUARD_DRIVE_OUT, .GUARD_DRIVE_OE,
    .CODE_OUTPUT_ENABLE, .CODE_OUT, .CODE_OE, .EARLY_DETECT_FLAG, .DELAYED_STEER_FLAG,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
    .AVS_WAITREQUEST, .IRQ);
  code_reader rdr (.clk(CLK), .code_oe(CODE_OE), .code_out(CODE_OUT),
                   .code_enable(CODE_OUTPUT_ENABLE));

  always #25 CLK = ~CLK;

  always @(posedge CLK) begin
    if (tone_on) begin
      lo_cnt <= (lo_cnt >= lo_half - 1) ? 0 : lo_cnt + 1;
      hi_cnt <= (hi_cnt >= hi_half - 1) ? 0 : hi_cnt + 1;
      if (lo_cnt >= lo_half - 1) LOW_TONE <= ~LOW_TONE;
      if (hi_cnt >= hi_half - 1) HIGH_TONE <= ~HIGH_TONE;
    end
  end

  // code must settle 80 cycles (4 us) before the delayed flag rises
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    code_prev <= CODE_OUT;
    ds_prev <= DELAYED_STEER_FLAG;
    if (CODE_OUT !== code_prev) chg_t <= cyc;
    if (DELAYED_STEER_FLAG === 1'b1 && ds_prev === 1'b0)
      chk("code setup", 32'(cyc - chg_t >= 80), 1);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    q = AVS_READDATA;
    chk("bus answer", 32'(n < 50), 1);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, rd);
    chk(nm, rd, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  // sel 1 waits on the early flag, 0 on the delayed flag
  task automatic wait_lvl(input logic sel, input logic lvl, input int lim, input string nm);
    int n;
    n = 0;
    while ((sel ? EARLY_DETECT_FLAG : DELAYED_STEER_FLAG) !== lvl && n < lim) begin
      @(posedge CLK);
      n++;
    end
    chk(nm, 32'(n < lim), 1);
  endtask

  task automatic tone(input int i);
    lo_half <= 10000000 / (key_rows[i][0] * SCALE);
    hi_half <= 10000000 / (key_rows[i][1] * SCALE);
    tone_on <= 1'b1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge CLK);
    error_cnt++;
    stop_test;
  end

  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    chk("reset outs", 32'({EARLY_DETECT_FLAG, DELAYED_STEER_FLAG, GUARD_DRIVE_OUT,
        CODE_OE, IRQ, CODE_OUT}), 0);
    reg_chk(`REG_CTRL_OFS, 32'h0, "ctrl rst");
    reg_chk(`REG_GTP_OFS, 32'h1e, "gtp rst");
    reg_chk(`REG_GTA_OFS, 32'h1e, "gta rst");
    reg_chk(`REG_IRQ_EN_OFS, 32'h0, "irq en rst");
    reg_chk(`REG_CODE_OFS, 32'h0, "code rst");
    reg_chk(8'h20, 32'h0, "unmapped");
    wr(`REG_IRQ_EN_OFS, 32'h7);
    // short guards keep each key to a few thousand cycles
    wr(`REG_GTP_OFS, 32'd4);
    wr(`REG_GTA_OFS, 32'd4);
    for (int i = 0; i < 16; i++) begin
      tone(i);
      wait_lvl(1'b0, 1'b1, 6000, "present");
      chk("early", 32'(EARLY_DETECT_FLAG), 1);
      chk("guard", 32'({GUARD_DRIVE_OUT, GUARD_DRIVE_OE}), 3);
      chk("bus off", 32'(CODE_OE), 0);
      reg_chk(`REG_CODE_OFS, key_rows[i][2], "code reg");
      if (i == 0) reg_chk(`REG_STATUS_OFS, 32'h27, "status");
      rdr.read_code(rd4);
      chk("code bus", 32'(rd4), key_rows[i][2]);
      if (i == 0) begin
        chk("irq set", 32'(IRQ), 1);
        reg_chk(`REG_IRQ_STAT_OFS, 32'h1, "irq stat");
        wr(`REG_IRQ_EN_OFS, 32'h0);
        @(posedge CLK);
        chk("irq masked", 32'(IRQ), 0);
        wr(`REG_IRQ_CLR_OFS, 32'h1);
        wr(`REG_IRQ_EN_OFS, 32'h7);
        @(posedge CLK);
        chk("irq clear", 32'(IRQ), 0);
      end
      tone_on <= 1'b0;
      wait_lvl(1'b0, 1'b0, 3000, "absent");
      chk("early off", 32'({EARLY_DETECT_FLAG, GUARD_DRIVE_OUT}), 0);
      rdr.read_code(rd4);
      chk("code held", 32'(rd4), key_rows[i][2]);
      repeat (3) @(posedge CLK);
      chk("bus released", 32'(CODE_OE), 0);
    end
    // burst shorter than the present guard
    wr(`REG_GTP_OFS, 32'd60);
    tone(4);
    wait_lvl(1'b1, 1'b1, 3000, "burst seen");
    tone_on <= 1'b0;
    wait_lvl(1'b1, 1'b0, 3000, "burst gone");
    chk("burst flag", 32'(DELAYED_STEER_FLAG), 0);
    reg_chk(`REG_CODE_OFS, 32'h0, "burst code");
    // registered, pause and rejected burst have all been seen by now
    reg_chk(`REG_IRQ_STAT_OFS, 32'h7, "irq events");
    chk("irq level", 32'(IRQ), 1);
    wr(`REG_IRQ_CLR_OFS, 32'h7);
    reg_chk(`REG_IRQ_STAT_OFS, 32'h0, "irq cleared");
    wr(`REG_GTP_OFS, 32'd4);
    // dropout shorter than the absent guard
    wr(`REG_GTA_OFS, 32'd60);
    tone(8);
    wait_lvl(1'b0, 1'b1, 6000, "drop start");
    tone_on <= 1'b0;
    wait_lvl(1'b1, 1'b0, 3000, "drop early");
    tone(8);
    wait_lvl(1'b1, 1'b1, 3000, "drop back");
    chk("drop flag", 32'(DELAYED_STEER_FLAG), 1);
    reg_chk(`REG_CODE_OFS, 32'h9, "drop code");
    tone_on <= 1'b0;
    wait_lvl(1'b0, 1'b0, 6000, "drop end");
    wr(`REG_GTA_OFS, 32'd4);
    // external steering level
    wr(`REG_CTRL_OFS, 32'h1);
    tone(2);
    wait_lvl(1'b1, 1'b1, 3000, "ext early");
    repeat (300) @(posedge CLK);
    chk("ext wait", 32'(DELAYED_STEER_FLAG), 0);
    STEER_IN <= 1'b1;
    wait_lvl(1'b0, 1'b1, 1000, "ext steer");
    reg_chk(`REG_CODE_OFS, 32'h3, "ext code");
    tone_on <= 1'b0;
    wait_lvl(1'b1, 1'b0, 3000, "ext gap");
    tone(6);
    wait_lvl(1'b1, 1'b1, 3000, "ext second");
    repeat (300) @(posedge CLK);
    reg_chk(`REG_CODE_OFS, 32'h3, "ext locked");
    STEER_IN <= 1'b0;
    wait_lvl(1'b0, 1'b0, 100, "ext release");
    tone_on <= 1'b0;
    wr(`REG_CTRL_OFS, 32'h0);
    // reset in mid-run with a nonzero code latched and guards rewritten
    RST <= 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    chk("rerun outs", 32'({EARLY_DETECT_FLAG, DELAYED_STEER_FLAG, GUARD_DRIVE_OUT,
        CODE_OE, IRQ, CODE_OUT}), 0);
    reg_chk(`REG_CODE_OFS, 32'h0, "rerun code");
    reg_chk(`REG_GTP_OFS, 32'h1e, "rerun gtp");
    stop_test;
  end
endmodule // test_dual_tone_decode_steering
